// file: hdl/acs_consts.svh
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH
// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define ACS_OFF_CTRL 12'h000
`define ACS_OFF_TIMING 12'h004
`define ACS_OFF_CMD 12'h008
`define ACS_OFF_STATUS 12'h00c
`define ACS_OFF_RESULT 12'h010
`define ACS_OFF_SAMPLE 12'h014
// ---------------------------------------------
// field positions and reset values
// ---------------------------------------------
`define ACS_B_EN 0
`define ACS_B_KEEP 1
`define ACS_B_CONT 2
`define ACS_B_MODE 3
`define ACS_B_AMP 5
`define ACS_B_REF 6
`define ACS_B_SLOW 7
`define ACS_B_SDUR 0
`define ACS_B_HOLD 8
`define ACS_B_NACC 16
`define ACS_B_START 0
`define ACS_CTRL_RST 8'h00
`define ACS_SDUR_RST 8'h00
`define ACS_HOLD_RST 8'h00
`define ACS_NACC_RST 4'h0
`define ACS_NACC_MAX 4'ha
// ---------------------------------------------
// timing
// ---------------------------------------------
`define ACS_CLK_MHZ 100
`define ACS_NS2CYC(ns) (((ns) * `ACS_CLK_MHZ + 999) / 1000)
`define ACS_INIT_ADC_NS 10000
`define ACS_INIT_AMP_NS 20000
`define ACS_INIT_REF_NS 60000
`define ACS_INIT_SLOW_NS 35000
`define ACS_INIT_ADC_CYC `ACS_NS2CYC(`ACS_INIT_ADC_NS)
`define ACS_INIT_AMP_CYC `ACS_NS2CYC(`ACS_INIT_AMP_NS)
`define ACS_INIT_REF_CYC `ACS_NS2CYC(`ACS_INIT_REF_NS)
`define ACS_INIT_SLOW_CYC `ACS_NS2CYC(`ACS_INIT_SLOW_NS)
`define ACS_SYS_PER_ADC 2
`define ACS_CONV12_ADC 13
`define ACS_CONV8_ADC 9
`define ACS_LATCH_SYS 2
`define ACS_ACC_EXTRA_SYS 1
`endif

// file: hdl/acs_pkg.sv
package acs_pkg;
  typedef enum logic [2:0] {
    ACS_IDLE, ACS_INIT, ACS_SAMPLE, ACS_HOLD, ACS_CONV, ACS_LATCH
  } acs_state_t;
  typedef enum logic [1:0] {
    ACS_SINGLE12, ACS_SINGLE8, ACS_SERIES, ACS_BURST
  } acs_mode_t;
  typedef struct packed {
    acs_state_t st;
    logic [9:0] tmr;
    logic [7:0] ctrl;
    logic [7:0] sdur;
    logic [7:0] hold;
    logic [3:0] nacc;
    logic [10:0] nsmp;
    logic analog_on;
    logic [11:0] conv;
    logic [11:0] sample;
    logic [21:0] result;
    logic rvalid;
  } acs_main_t;
  typedef struct packed {
    logic [12:0] cnt;
  } acs_init_t;
  typedef struct packed {
    logic [21:0] total;
  } acs_acc_t;
endpackage

// file: hdl/acs_seq_if.sv
`timescale 1ns/1ps
interface acs_seq_if;
  logic init_go;
  logic need_amp;
  logic need_ref;
  logic need_slow;
  logic amp_ready;
  logic init_done;
  logic acc_clr;
  logic acc_add;
  logic [11:0] acc_sample;
  logic [21:0] acc_total;
  modport ctl (output init_go, need_amp, need_ref, need_slow, acc_clr, acc_add, acc_sample,
    input amp_ready, init_done, acc_total);
  modport init (input init_go, need_amp, need_ref, need_slow, output amp_ready, init_done);
  modport acc (input acc_clr, acc_add, acc_sample, output acc_total);
endinterface

// file: hdl/acs_init_timer.sv
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_init_timer #(
  parameter logic [12:0] REF_CYC = 13'(`ACS_INIT_REF_CYC)
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  acs_seq_if.init s
);
  localparam logic [12:0] ADC_CYC = 13'(`ACS_INIT_ADC_CYC);
  localparam logic [12:0] AMP_CYC = 13'(`ACS_INIT_AMP_CYC);
  localparam logic [12:0] SLOW_CYC = 13'(`ACS_INIT_SLOW_CYC);
  function automatic logic [12:0] max2(input logic [12:0] a, input logic [12:0] b);
    return (a > b) ? a : b;
  endfunction
  acs_pkg::acs_init_t q;
  acs_pkg::acs_init_t n;
  logic [12:0] tgt;
  // modules power up in parallel: the slowest one sets the wait
  always_comb begin
    tgt = ADC_CYC;
    if (s.need_amp) tgt = max2(tgt, AMP_CYC);
    if (s.need_ref) tgt = max2(tgt, REF_CYC);
    if (s.need_slow) tgt = max2(tgt, SLOW_CYC);
    s.init_done = s.init_go && (q.cnt >= tgt - 13'h0001);
    s.amp_ready = s.init_go && s.need_amp && (q.cnt >= AMP_CYC - 13'h0001);
    n = q;
    if (!s.init_go) n.cnt = 13'h0000;
    else if (!s.init_done) n.cnt = q.cnt + 13'h0001;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) q <= '0;
    else if (ce_in) q <= n;
  end
endmodule // acs_init_timer

// file: hdl/acs_accum.sv
`timescale 1ns/1ps
module acs_accum (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  acs_seq_if.acc s
);
  acs_pkg::acs_acc_t q;
  acs_pkg::acs_acc_t n;
  // 1024 samples of 12 bits fit 22 bits, so no overflow check
  always_comb begin
    n = q;
    if (s.acc_clr) n.total = 22'h000000;
    if (s.acc_add) n.total = n.total + {10'h000, s.acc_sample};
    s.acc_total = q.total;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) q <= '0;
    else if (ce_in) q <= n;
  end
endmodule // acs_accum

// file: hdl/acs_adc_seq.sv
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_adc_seq #(
  parameter logic [12:0] INIT_REF_CYC = 13'(`ACS_INIT_REF_CYC)
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic trigger_in,
  input wire logic [11:0] conv_data_in,
  output logic adc_on_out,
  output logic amp_on_out,
  output logic amp_sample_out,
  output logic sample_hold_out,
  output logic conv_active_out,
  output logic busy_out,
  output logic result_valid_out,
  output logic [21:0] result_out
);
  // -------------------------------------------
  // helpers
  // -------------------------------------------
  function automatic logic [9:0] sys_cyc(input logic [8:0] adc);
    return 10'(adc * `ACS_SYS_PER_ADC);
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  acs_pkg::acs_main_t q;
  acs_pkg::acs_main_t n;
  acs_seq_if s ();

  acs_init_timer #(
    .REF_CYC(INIT_REF_CYC)
  ) u_init (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .s(s.init)
  );

  acs_accum u_acc (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .s(s.acc)
  );

  // -------------------------------------------
  // decode
  // -------------------------------------------
  acs_pkg::acs_mode_t mode;
  logic en;
  logic keep;
  logic cont;
  logic amp;
  logic accm;
  logic last;
  logic tz;
  logic acc_wr;
  logic start;
  logic mapped;
  logic [10:0] tgt_n;
  logic [11:0] shaped;
  logic [9:0] samp_ld;
  logic [9:0] hold_ld;
  logic [9:0] conv_ld;
  logic [9:0] latch_ld;

  assign mode = acs_pkg::acs_mode_t'(q.ctrl[`ACS_B_MODE +: 2]);
  assign en = q.ctrl[`ACS_B_EN];
  assign keep = q.ctrl[`ACS_B_KEEP];
  assign cont = q.ctrl[`ACS_B_CONT];
  assign amp = q.ctrl[`ACS_B_AMP];
  assign accm = (mode == acs_pkg::ACS_SERIES) || (mode == acs_pkg::ACS_BURST);
  assign tgt_n = 11'h001 << q.nacc;
  assign last = !accm || (q.nsmp == tgt_n - 11'h001);
  assign tz = q.tmr == 10'h000;
  assign shaped = (mode == acs_pkg::ACS_SINGLE8) ? {4'h0, conv_data_in[11:4]} : conv_data_in;
  assign mapped = hit(paddr_in, `ACS_OFF_CTRL) || hit(paddr_in, `ACS_OFF_TIMING)
    || hit(paddr_in, `ACS_OFF_CMD) || hit(paddr_in, `ACS_OFF_STATUS)
    || hit(paddr_in, `ACS_OFF_RESULT) || hit(paddr_in, `ACS_OFF_SAMPLE);
  assign acc_wr = psel_in && penable_in && pwrite_in && ce_in;
  assign start = trigger_in || (acc_wr && hit(paddr_in, `ACS_OFF_CMD)
    && pwdata_in[`ACS_B_START]);

  // sample window of length plus one
  assign samp_ld = sys_cyc({1'b0, q.sdur} + 9'h001) - 10'h001;
  // amplifier hold of length plus one half
  assign hold_ld = sys_cyc({1'b0, q.hold});
  assign conv_ld = sys_cyc((mode == acs_pkg::ACS_SINGLE8) ? 9'(`ACS_CONV8_ADC)
    : 9'(`ACS_CONV12_ADC)) - 10'h001;
  assign latch_ld = (accm && last) ? 10'(`ACS_LATCH_SYS + `ACS_ACC_EXTRA_SYS - 1)
    : 10'(`ACS_LATCH_SYS - 1);

  // -------------------------------------------
  // analog front end
  // -------------------------------------------
  // init needs
  assign s.init_go = q.st == acs_pkg::ACS_INIT;
  assign s.need_amp = amp;
  assign s.need_ref = q.ctrl[`ACS_B_REF];
  assign s.need_slow = q.ctrl[`ACS_B_SLOW];
  assign s.acc_sample = shaped;

  assign adc_on_out = (q.st != acs_pkg::ACS_IDLE) || q.analog_on;
  assign amp_on_out = amp && adc_on_out;
  // early amplifier sampling, stays sampling when idle with modules kept on
  assign amp_sample_out = amp_on_out && (q.st != acs_pkg::ACS_HOLD)
    && !(s.init_go && !s.amp_ready);
  assign sample_hold_out = ((q.st == acs_pkg::ACS_SAMPLE) && !amp)
    || (q.st == acs_pkg::ACS_HOLD);
  assign conv_active_out = q.st == acs_pkg::ACS_CONV;
  assign busy_out = q.st != acs_pkg::ACS_IDLE;
  assign result_valid_out = q.rvalid;
  assign result_out = q.result;

  // -------------------------------------------
  // apb slave
  // -------------------------------------------
  // zero wait states; a low clock enable stalls the access
  assign pready_out = ce_in;
  assign pslverr_out = psel_in && penable_in && !mapped;

  always_comb begin
    prdata_out = 32'h00000000;
    case (paddr_in)
      `ACS_OFF_CTRL: prdata_out = {24'h000000, q.ctrl};
      `ACS_OFF_TIMING: prdata_out = {12'h000, q.nacc, q.hold, q.sdur};
      `ACS_OFF_STATUS: prdata_out = {11'h000, q.nsmp, 4'h0, 3'(q.st), q.analog_on,
        s.init_go, busy_out};
      `ACS_OFF_RESULT: prdata_out = {10'h000, q.result};
      `ACS_OFF_SAMPLE: prdata_out = {20'h00000, q.sample};
      default: prdata_out = 32'h00000000;
    endcase
  end

  // -------------------------------------------
  // sequencer
  // -------------------------------------------
  always_comb begin
    n = q;
    n.rvalid = 1'b0;
    n.tmr = tz ? q.tmr : q.tmr - 10'h001;
    s.acc_clr = 1'b0;
    s.acc_add = 1'b0;
    if (acc_wr) begin
      case (paddr_in)
        `ACS_OFF_CTRL: n.ctrl = pwdata_in[7:0];
        `ACS_OFF_TIMING: begin
          n.sdur = pwdata_in[`ACS_B_SDUR +: 8];
          n.hold = pwdata_in[`ACS_B_HOLD +: 8];
          n.nacc = (pwdata_in[`ACS_B_NACC +: 4] > `ACS_NACC_MAX) ? `ACS_NACC_MAX
            : pwdata_in[`ACS_B_NACC +: 4];
        end
        default: ;
      endcase
    end
    case (q.st)
      acs_pkg::ACS_IDLE: begin
        // one sample per trigger in series
        if (en && start) begin
          if (q.nsmp == 11'h000) s.acc_clr = 1'b1;
          if (q.analog_on) begin
            n.st = acs_pkg::ACS_SAMPLE;
            n.tmr = samp_ld;
          end else begin
            n.st = acs_pkg::ACS_INIT;
          end
        end
      end
      acs_pkg::ACS_INIT: begin
        if (s.init_done) begin
          n.analog_on = 1'b1;
          n.st = acs_pkg::ACS_SAMPLE;
          n.tmr = samp_ld;
        end
      end
      acs_pkg::ACS_SAMPLE: begin
        if (tz && amp) begin
          n.st = acs_pkg::ACS_HOLD;
          n.tmr = hold_ld;
        end else if (tz) begin
          n.st = acs_pkg::ACS_CONV;
          n.tmr = conv_ld;
        end
      end
      acs_pkg::ACS_HOLD: begin
        if (tz) begin
          n.st = acs_pkg::ACS_CONV;
          n.tmr = conv_ld;
        end
      end
      acs_pkg::ACS_CONV: begin
        if (tz) begin
          s.acc_add = 1'b1;
          n.conv = shaped;
          // burst goes straight back to sampling
          if (mode == acs_pkg::ACS_BURST && !last) begin
            n.sample = shaped;
            n.nsmp = q.nsmp + 11'h001;
            n.st = acs_pkg::ACS_SAMPLE;
            n.tmr = samp_ld;
          end else begin
            n.st = acs_pkg::ACS_LATCH;
            n.tmr = latch_ld;
          end
        end
      end
      acs_pkg::ACS_LATCH: begin
        if (tz) begin
          n.sample = q.conv;
          if (last) begin
            n.result = accm ? s.acc_total : {10'h000, q.conv};
            n.rvalid = 1'b1;
            n.nsmp = 11'h000;
          end else begin
            n.nsmp = q.nsmp + 11'h001;
          end
          // restart with no trigger, no init
          if (last && cont) begin
            s.acc_clr = 1'b1;
            n.st = acs_pkg::ACS_SAMPLE;
            n.tmr = samp_ld;
          end else begin
            n.st = acs_pkg::ACS_IDLE;
            if (!keep) n.analog_on = 1'b0;
          end
        end
      end
      default: n.st = acs_pkg::ACS_IDLE;
    endcase
    if (!en) begin
      n.st = acs_pkg::ACS_IDLE;
      n.analog_on = 1'b0;
      n.nsmp = 11'h000;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
      q.st <= acs_pkg::ACS_IDLE;
      q.ctrl <= `ACS_CTRL_RST;
      q.sdur <= `ACS_SDUR_RST;
      q.hold <= `ACS_HOLD_RST;
      q.nacc <= `ACS_NACC_RST;
    end else if (ce_in) begin
      q <= n;
    end
  end

  // -------------------------------------------
  // checks
  // -------------------------------------------
  logic [10:0] ph_cnt;
  logic leave;
  assign leave = ce_in && (n.st != q.st);

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) ph_cnt <= 11'h000;
    else if (leave) ph_cnt <= 11'h000;
    else if (ce_in) ph_cnt <= ph_cnt + 11'h001;
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_conv_end;
    leave && (q.st == acs_pkg::ACS_CONV);
  endsequence

  sequence s_done;
    leave && (q.st == acs_pkg::ACS_LATCH) && (n.st == acs_pkg::ACS_IDLE);
  endsequence

  sequence s_result;
    result_valid_out ##0 (cont && en);
  endsequence

  conv_len_a: assert property (
    (s_conv_end ##0 en) |-> ph_cnt == {1'b0, conv_ld})
    else $error("conversion phase length wrong");

  samp_len_a: assert property (
    (leave && q.st == acs_pkg::ACS_SAMPLE && en) |-> ph_cnt == {1'b0, samp_ld})
    else $error("sample phase length wrong");

  hold_len_a: assert property (
    (leave && q.st == acs_pkg::ACS_HOLD && en) |-> ph_cnt == {1'b0, hold_ld} && amp)
    else $error("amplifier hold length wrong");

  latch_len_a: assert property (
    (leave && q.st == acs_pkg::ACS_LATCH && en)
      |-> ph_cnt == ((accm && last) ? 11'h002 : 11'h001))
    else $error("result latency wrong");

  keep_on_a: assert property (
    (s_done ##0 keep && en) |=> adc_on_out && !busy_out)
    else $error("analog modules switched off despite keep");

  busy_init_a: assert property (
    (q.st == acs_pkg::ACS_INIT) |-> busy_out && !sample_hold_out && !conv_active_out)
    else $error("busy low during init");

  cont_restart_a: assert property (
    s_result |-> q.st == acs_pkg::ACS_SAMPLE && ph_cnt == 11'h000)
    else $error("continuous mode did not restart");

  burst_gap_a: assert property (
    (s_conv_end ##0 (mode == acs_pkg::ACS_BURST && !last && en))
      |=> q.st == acs_pkg::ACS_SAMPLE && q.tmr == samp_ld)
    else $error("burst sample spacing wrong");

  amp_early_a: assert property (
    (s.init_go && s.amp_ready) |-> amp_sample_out)
    else $error("amplifier not sampling after its init");

  amp_idle_a: assert property (
    (q.st == acs_pkg::ACS_IDLE && q.analog_on && amp) |-> amp_sample_out)
    else $error("powered amplifier left input sampling");

  acc_done_a: assert property (
    (result_valid_out && accm && !$past(cont)) |-> q.nsmp == 11'h000 && !busy_out)
    else $error("accumulated result declared early");
endmodule // acs_adc_seq

// file: verification/acs_afe_model.sv
`timescale 1ns/1ps
module acs_afe_model #(
  parameter logic [11:0] LEVEL = 12'h5a3
) (
  input wire logic clk_in,
  input wire logic conv_active_in,
  output logic [11:0] conv_data_out
);
  logic [11:0] drift_r = 12'h000;
  always_ff @(posedge clk_in) begin
    drift_r <= drift_r + 12'h001;
  end
  // outside conversion the lines keep moving, so a wrong sampling moment shows
  assign conv_data_out = conv_active_in ? LEVEL : ~drift_r;
endmodule // acs_afe_model

// file: verification/tb_adc_conversion_sequencer_timing.sv
`timescale 1ns/1ps
`include "acs_consts.svh"
module tb_adc_conversion_sequencer_timing;
  logic clk, rst_n, psel, penable, pwrite, trigger, pready, pslverr;
  logic adc_on, amp_on, amp_sample, sample_hold, conv_active, busy, result_valid;
  logic [11:0] paddr;
  logic [11:0] conv_data;
  logic [31:0] pwdata, prdata, rd;
  logic [21:0] result;
  logic err;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ref settling shortened to keep the run brief, still longer than the ADC wait but below the amplifier and slow waits
  acs_adc_seq #(.INIT_REF_CYC(13'h04b0)) acs_adc_seq_i (.core_clk_in(clk), .rst_n_in(rst_n),
    .ce_in(1'b1), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .trigger_in(trigger), .conv_data_in(conv_data), .adc_on_out(adc_on), .amp_on_out(amp_on),
    .amp_sample_out(amp_sample), .sample_hold_out(sample_hold),
    .conv_active_out(conv_active), .busy_out(busy), .result_valid_out(result_valid),
    .result_out(result));
  acs_afe_model acs_afe_model_i (.clk_in(clk), .conv_active_in(conv_active),
    .conv_data_out(conv_data));
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic end_of_test();
    $display("counts: %0d checks, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input logic [7:0] ctrl, input logic [31:0] timing);
    apb(1'b1, `ACS_OFF_CTRL, 32'h0);
    apb(1'b1, `ACS_OFF_TIMING, timing);
    apb(1'b1, `ACS_OFF_CTRL, {24'h0, ctrl});
  endtask
  // t counts clocks from the edge that takes the trigger to the result pulse
  task automatic run(input int exp_t, input int exp_c, input logic [21:0] exp_r, input int probe,
    input int exp_h);
    int t;
    int c;
    int h;
    t = 0;
    c = 0;
    h = 0;
    @(posedge clk) trigger <= 1'b1;
    @(posedge clk) trigger <= 1'b0;
    while (result_valid !== 1'b1 && t < 8000) begin
      @(negedge clk);
      t++;
      if (conv_active === 1'b1) c++;
      if (sample_hold === 1'b1) h++;
      if (t == 1) chk(busy, 1'b1);
      if (probe > 0 && t == probe - 10) chk(amp_sample, 1'b0);
      if (probe > 0 && t == probe + 10) chk({amp_sample, busy}, 2'h3);
    end
    chk(t, exp_t);
    chk(c, exp_c);
    chk(result, exp_r);
    chk(h, exp_h);
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_cold();
    cfg(8'h41, 32'h2);
    run(1235, 26, 22'h5a3, 0, 6);
    chk(adc_on, 1'b0);
    $display("test cold single done");
  endtask
  task automatic t_amp_keep();
    cfg(8'h23, 32'h0302);
    run(2042, 26, 22'h5a3, 0, 7);
    run(42, 26, 22'h5a3, 0, 7);
    chk({adc_on, amp_on, amp_sample}, 3'h7);
    apb(1'b1, `ACS_OFF_CTRL, 32'h2b);
    run(34, 18, 22'h05a, 0, 7);
    $display("test amplifier keep done");
  endtask
  task automatic t_cont();
    int n;
    apb(1'b1, `ACS_OFF_CTRL, 32'h27);
    run(42, 26, 22'h5a3, 0, 7);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (result_valid !== 1'b1 && n < 500);
    chk(n, 41);
    apb(1'b1, `ACS_OFF_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    chk(busy, 1'b0);
    $display("test continuous done");
  endtask
  task automatic t_plain_keep();
    cfg(8'h03, 32'h2);
    run(1035, 26, 22'h5a3, 0, 6);
    run(35, 26, 22'h5a3, 0, 6);
    apb(1'b1, `ACS_OFF_CTRL, 32'h0b);
    run(27, 18, 22'h05a, 0, 6);
    $display("test plain keep done");
  endtask
  task automatic t_series();
    int n;
    logic seen;
    cfg(8'h13, 32'h0001_0002);
    seen = 1'b0;
    n = 0;
    @(posedge clk) trigger <= 1'b1;
    @(posedge clk) trigger <= 1'b0;
    do begin
      @(negedge clk);
      n++;
      seen = seen | (result_valid === 1'b1);
    end while (busy !== 1'b0 && n < 3000);
    chk(n, 1035);
    chk(seen, 1'b0);
    run(36, 26, 22'h000b46, 0, 6);
    $display("test series done");
  endtask
  task automatic t_burst();
    int n;
    // sample length 12 keeps burst sampling legal
    cfg(8'h1b, 32'h0002_000c);
    run(1212, 104, 22'h00168c, 0, 104);
    apb(1'b0, `ACS_OFF_RESULT, 32'h0);
    chk(rd, 32'h0000_168c);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // software start through the command word, modules still powered
    apb(1'b1, `ACS_OFF_CMD, 32'h1);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (result_valid !== 1'b1 && n < 500);
    chk(n, 212);
    chk(result, 22'h00168c);
    $display("test burst and bus done");
  endtask
  task automatic t_amp_init();
    cfg(8'ha1, 32'h0302);
    run(3542, 26, 22'h5a3, 2000, 7);
    $display("test amplifier init done");
  endtask
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    trigger = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_cold();
    t_amp_keep();
    t_cont();
    t_plain_keep();
    t_series();
    t_burst();
    t_amp_init();
    end_of_test();
  end
endmodule // tb_adc_conversion_sequencer_timing
